/* core/error_flag_params.svh */
`ifndef ERROR_FLAG_PARAMS_SVH
`define ERROR_FLAG_PARAMS_SVH
`define FLAG_WIDTH 16
`define BIT_WAIT_HOST 0
`define BIT_NO_POWER 1
`define BIT_DRIVER_FAULT 2
`define BIT_INPUT_INVALID 3
`define BIT_INPUT_DISCONNECT 4
`define BIT_FEEDBACK_DISCONNECT 5
`define BIT_SOFT_OVERCURRENT 6
`define BIT_SERIAL_SIGNAL 7
`define BIT_SERIAL_OVERRUN 8
`define BIT_RX_BUFFER_FULL 9
`define BIT_SERIAL_CRC 10
`define BIT_SERIAL_PROTOCOL 11
`define BIT_SERIAL_TIMEOUT 12
`define BIT_HARD_OVERCURRENT 13
`define FLAGS_RESET 16'h0000
`define TIMEOUT_TICK_NS 10000000
`define CLK_PERIOD_NS 50
`define TIMEOUT_TICK_CYCLES (`TIMEOUT_TICK_NS / `CLK_PERIOD_NS)
`endif

/* core/error_flag_pkg.sv */
package error_flag_pkg;
   typedef enum logic [1:0]
   {
      RESP_DISABLED = 2'h0,
      RESP_ENABLED = 2'h1,
      RESP_LATCHED = 2'h3
   } response_t;
   typedef enum logic [1:0]
   {
      XFER_IDLE = 2'h0,
      XFER_LOW = 2'h1,
      XFER_HIGH = 2'h3
   } xfer_state_t;
endpackage

/* core/hard_overcurrent_counter.sv */
`timescale 1ns/1ps
`include "error_flag_params.svh"
module hard_overcurrent_counter
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic period_tick,
   input wire logic hw_limiting,
   input wire logic [7:0] threshold,
   output logic fault
);
   logic [7:0] count_q;
   // =====================================================
   // Persistence count.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         count_q <= 8'h00;
      end
      else if (period_tick)
      begin
         if (!hw_limiting)
         begin
            count_q <= 8'h00;
         end
         else if (count_q != 8'hFF)
         begin
            count_q <= count_q + 8'h01;
         end
      end
   end
   assign fault = hw_limiting && (threshold != 8'h00) && (count_q >= threshold);
endmodule

/* core/serial_timeout_timer.sv */
`timescale 1ns/1ps
`include "error_flag_params.svh"
module serial_timeout_timer
#(
   parameter int TICK_CYCLES = `TIMEOUT_TICK_CYCLES
)
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [15:0] timeout_ticks,
   input wire logic restart,
   output logic expired
);
   logic [23:0] pre_q;
   logic [15:0] ticks_q;
   logic tick;
   assign tick = (pre_q == 24'(TICK_CYCLES - 1));
   // =====================================================
   // Prescaler and tick counter.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pre_q <= 24'h000000;
         ticks_q <= 16'h0000;
      end
      else if (restart || timeout_ticks == 16'h0000)
      begin
         pre_q <= 24'h000000;
         ticks_q <= 16'h0000;
      end
      else
      begin
         pre_q <= tick ? 24'h000000 : pre_q + 24'h000001;
         if (tick && ticks_q != timeout_ticks)
         begin
            ticks_q <= ticks_q + 16'h0001;
         end
      end
   end
   assign expired = (timeout_ticks != 16'h0000) && (ticks_q == timeout_ticks);
endmodule

/* core/motor_error_flag_manager.sv */
// Contract
// - Keep a 16-bit stop-cause word; a 1 bit stops the motor.
// - A read may clear latched stop-cause bits, never the wait-for-host bit.
// - Keep a 16-bit seen-since-clear word recording every error, even disabled.
// - A read may clear the whole seen-since-clear word.
// - Disabled errors never set stop-cause bits but are still recorded.
// - Enabled errors follow their condition in the stop-cause word.
// - Latched errors hold their bit and raise wait-for-host until cleared.
// - Per-error immediate-stop option; supply-low and driver fault always immediate.
// - Flag words are sent low byte first, then high byte.
// - Wait-for-host set at host-mode startup, stop command, latched error; cleared by drive commands.
// - Bit 1 marks motor supply too low.
// - Bit 2 marks an external driver fault.
// - Bit 3 marks invalid pulse input, only in pulse input mode.
// - Bit 4 marks input out of range or analog input disconnect.
// - Bit 5 marks feedback out of range or analog feedback disconnect.
// - Bit 6 marks current above the soft limit.
// - Bit 7 marks a serial byte without a valid stop bit.
// - Bit 8 marks receiver hardware buffer overrun.
// - Bit 9 marks a byte dropped by the full receive byte buffer.
// - Bit 10 marks a bad packet checksum when checking is on.
// - Bit 11 marks a malformed serial or two-wire packet.
// - Bit 12 marks a timeout expiring without a clearing command.
// - Bit 13 marks hardware current limiting persisting the set periods.
// - Error line high while any stop-cause bit besides wait-for-host is set.
`timescale 1ns/1ps
`include "error_flag_params.svh"
module motor_error_flag_manager
#(
   parameter int TICK_CYCLES = `TIMEOUT_TICK_CYCLES
)
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [31:0] response_cfg,
   input wire logic [15:0] immediate_stop_cfg,
   input wire logic host_input_mode,
   input wire logic pulse_input_mode,
   input wire logic analog_input_mode,
   input wire logic analog_feedback_mode,
   input wire logic input_detect_en,
   input wire logic feedback_detect_en,
   input wire logic crc_check_en,
   input wire logic [15:0] timeout_ticks,
   input wire logic [7:0] hard_oc_threshold,
   input wire logic motor_supply_input_low,
   input wire logic driver_fault,
   input wire logic pulse_invalid,
   input wire logic [11:0] input_value,
   input wire logic [11:0] input_error_min,
   input wire logic [11:0] input_error_max,
   input wire logic input_power_disconnect,
   input wire logic [11:0] feedback_value,
   input wire logic [11:0] feedback_error_min,
   input wire logic [11:0] feedback_error_max,
   input wire logic feedback_power_disconnect,
   input wire logic [15:0] current_ma,
   input wire logic [15:0] soft_current_limit,
   input wire logic rx_stop_bit_bad,
   input wire logic rx_hw_overrun,
   input wire logic rx_byte_dropped,
   input wire logic packet_crc_bad,
   input wire logic packet_malformed,
   input wire logic period_tick,
   input wire logic hw_current_limiting,
   input wire logic cmd_set_target,
   input wire logic cmd_stop_motor,
   input wire logic cmd_force_duty_target,
   input wire logic cmd_force_duty,
   input wire logic read_req,
   input wire logic read_seen,
   input wire logic read_clear,
   output logic read_busy,
   output logic read_valid,
   output logic [7:0] read_byte,
   output logic [15:0] stop_cause_flags,
   output logic [15:0] seen_since_clear_flags,
   output logic motor_stop_req,
   output logic immediate_stop_req,
   output logic error_line
);
   // =====================================================
   // Error conditions.
   logic [15:0] cond;
   logic timeout_exp;
   logic hard_oc;
   logic clear_halting;
   logic timeout_restart;
   logic read_take;
   logic startup_q;
   logic [15:0] latch_q;
   logic [15:0] level_en;
   logic [15:0] latch_en;
   logic [15:0] stop_q;
   logic [15:0] seen_q;
   logic [15:0] snap_q;
   logic wait_q;
   error_flag_pkg::xfer_state_t xfer_q;
   assign read_take = read_req && (xfer_q == error_flag_pkg::XFER_IDLE);
   assign clear_halting = read_take && !read_seen && read_clear;
   assign timeout_restart = cmd_set_target || cmd_stop_motor || cmd_force_duty_target
      || cmd_force_duty || clear_halting;
   serial_timeout_timer #(.TICK_CYCLES(TICK_CYCLES)) timeout_timer
   (
      .clk(clk),
      .reset_n(reset_n),
      .timeout_ticks(timeout_ticks),
      .restart(timeout_restart),
      .expired(timeout_exp)
   );
   hard_overcurrent_counter hard_oc_counter
   (
      .clk(clk),
      .reset_n(reset_n),
      .period_tick(period_tick),
      .hw_limiting(hw_current_limiting),
      .threshold(hard_oc_threshold),
      .fault(hard_oc)
   );
   always_comb
   begin
      cond = 16'h0000;
      cond[`BIT_NO_POWER] = motor_supply_input_low;
      cond[`BIT_DRIVER_FAULT] = driver_fault;
      cond[`BIT_INPUT_INVALID] = pulse_input_mode && pulse_invalid;
      cond[`BIT_INPUT_DISCONNECT] = (input_value > input_error_max)
         || (input_value < input_error_min)
         || (analog_input_mode && input_detect_en && input_power_disconnect);
      cond[`BIT_FEEDBACK_DISCONNECT] = (feedback_value > feedback_error_max)
         || (feedback_value < feedback_error_min)
         || (analog_feedback_mode && feedback_detect_en && feedback_power_disconnect);
      cond[`BIT_SOFT_OVERCURRENT] = current_ma > soft_current_limit;
      cond[`BIT_SERIAL_SIGNAL] = rx_stop_bit_bad;
      cond[`BIT_SERIAL_OVERRUN] = rx_hw_overrun;
      cond[`BIT_RX_BUFFER_FULL] = rx_byte_dropped;
      cond[`BIT_SERIAL_CRC] = crc_check_en && packet_crc_bad;
      cond[`BIT_SERIAL_PROTOCOL] = packet_malformed;
      cond[`BIT_SERIAL_TIMEOUT] = timeout_exp;
      cond[`BIT_HARD_OVERCURRENT] = hard_oc;
   end
   // =====================================================
   // Response decode.
   always_comb
   begin
      level_en = 16'h0000;
      latch_en = 16'h0000;
      for (int i = 1; i < `FLAG_WIDTH; i++)
      begin
         level_en[i] = response_cfg[2*i +: 2] == error_flag_pkg::RESP_ENABLED;
         latch_en[i] = response_cfg[2*i +: 2] == error_flag_pkg::RESP_LATCHED;
      end
   end
   // =====================================================
   // Latched bits; a new event wins over a clear.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         latch_q <= `FLAGS_RESET;
      end
      else
      begin
         latch_q <= ((clear_halting ? 16'h0000 : latch_q) | (cond & latch_en)) & 16'hFFFE;
      end
   end
   // =====================================================
   // Wait-for-host bit.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         startup_q <= 1'b1;
         wait_q <= 1'b0;
      end
      else
      begin
         startup_q <= 1'b0;
         if ((startup_q && host_input_mode) || cmd_stop_motor || |(cond & latch_en))
         begin
            wait_q <= 1'b1;
         end
         else if (cmd_set_target || cmd_force_duty_target || cmd_force_duty)
         begin
            wait_q <= 1'b0;
         end
      end
   end
   // =====================================================
   // Stop-cause word, registered.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         stop_q <= `FLAGS_RESET;
      end
      else
      begin
         stop_q <= (cond & level_en) | latch_q | {15'h0000, wait_q};
      end
   end
   // =====================================================
   // Seen-since-clear word; a new event wins over a clear.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         seen_q <= `FLAGS_RESET;
      end
      else
      begin
         seen_q <= ((read_take && read_seen && read_clear) ? 16'h0000 : seen_q)
            | cond | {15'h0000, wait_q};
      end
   end
   // =====================================================
   // Two-byte read transfer.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         xfer_q <= error_flag_pkg::XFER_IDLE;
         snap_q <= 16'h0000;
         read_valid <= 1'b0;
         read_byte <= 8'h00;
      end
      else
      begin
         read_valid <= 1'b0;
         unique case (xfer_q)
            error_flag_pkg::XFER_IDLE:
            begin
               if (read_req)
               begin
                  snap_q <= read_seen ? seen_q : stop_q;
                  xfer_q <= error_flag_pkg::XFER_LOW;
               end
            end
            error_flag_pkg::XFER_LOW:
            begin
               read_byte <= snap_q[7:0];
               read_valid <= 1'b1;
               xfer_q <= error_flag_pkg::XFER_HIGH;
            end
            error_flag_pkg::XFER_HIGH:
            begin
               read_byte <= snap_q[15:8];
               read_valid <= 1'b1;
               xfer_q <= error_flag_pkg::XFER_IDLE;
            end
            default:
            begin
               xfer_q <= error_flag_pkg::XFER_IDLE;
            end
         endcase
      end
   end
   assign read_busy = xfer_q != error_flag_pkg::XFER_IDLE;
   // =====================================================
   // Stop requests and error line.
   assign stop_cause_flags = stop_q;
   assign seen_since_clear_flags = seen_q;
   assign motor_stop_req = |stop_q;
   assign immediate_stop_req = |(stop_q & (immediate_stop_cfg | 16'h0006));
   assign error_line = |stop_q[15:1];
endmodule

/* sim/motor_error_flag_manager_props.sv */
`timescale 1ns/1ps
// ==========================================================
// Checker on the error manager ports.
module motor_error_flag_manager_props
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [31:0] response_cfg,
   input wire logic [15:0] immediate_stop_cfg,
   input wire logic motor_supply_input_low,
   input wire logic driver_fault,
   input wire logic cmd_stop_motor,
   input wire logic read_req,
   input wire logic read_busy,
   input wire logic read_valid,
   input wire logic [15:0] stop_cause_flags,
   input wire logic [15:0] seen_since_clear_flags,
   input wire logic motor_stop_req,
   input wire logic immediate_stop_req,
   input wire logic error_line
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   chk_err_line: assert property (error_line == (|stop_cause_flags[15:1]))
      else $error("error line mismatch");
   chk_stop_req: assert property (motor_stop_req == (|stop_cause_flags))
      else $error("stop request mismatch");
   chk_hard_stop: assert property ((|stop_cause_flags[2:1]) |-> immediate_stop_req)
      else $error("hard stop missing");
   chk_imm_follow: assert property (immediate_stop_req
      == (|(stop_cause_flags & (immediate_stop_cfg | 16'h0006))))
      else $error("immediate stop mismatch");
   chk_enabled_set: assert property (driver_fault && response_cfg[5:4] == 2'h1
      |=> stop_cause_flags[2]) else $error("enabled bit not set");
   chk_enabled_clear: assert property (!driver_fault && response_cfg[5:4] == 2'h1
      |=> !stop_cause_flags[2]) else $error("enabled bit not cleared");
   chk_disabled_quiet: assert property (!stop_cause_flags[6] && response_cfg[13:12] == 2'h0
      |=> !stop_cause_flags[6]) else $error("disabled bit set");
   chk_latch_set: assert property (motor_supply_input_low && response_cfg[3:2] == 2'h3
      |-> ##[1:2] (stop_cause_flags[1] && stop_cause_flags[0])) else $error("latch not set");
   chk_latch_hold: assert property (stop_cause_flags[1] && response_cfg[3:2] == 2'h3
      && !read_req && !$past(read_req) |=> stop_cause_flags[1]) else $error("latched bit lost");
   chk_stop_wait: assert property (cmd_stop_motor |-> ##[1:2] stop_cause_flags[0])
      else $error("wait bit not set");
   chk_read_bytes: assert property (read_req && !read_busy
      |-> ##2 read_valid ##1 read_valid ##1 !read_busy) else $error("read timing wrong");
   chk_seen_record: assert property (driver_fault |-> ##[1:2] seen_since_clear_flags[2])
      else $error("seen bit missing");
endmodule

/* sim/host_model.sv */
`timescale 1ns/1ps
// ==========================================================
// Host side: issues reads and drive commands.
module host_model
(
   input wire logic clk,
   input wire logic read_busy,
   output logic read_req,
   output logic read_seen,
   output logic read_clear,
   output logic [3:0] cmds
);
   initial
   begin
      read_req = 1'b0;
      read_seen = 1'b0;
      read_clear = 1'b0;
      cmds = 4'h0;
   end
   task automatic do_read(input logic seen, input logic clear);
      while (read_busy === 1'b1)
      begin
         @(posedge clk);
         #2;
      end
      read_req = 1'b1;
      read_seen = seen;
      read_clear = clear;
      @(posedge clk);
      #2;
      read_req = 1'b0;
      repeat (4) @(posedge clk);
      #2;
   endtask
   task automatic send_cmd(input logic [3:0] which);
      cmds = which;
      @(posedge clk);
      #2;
      cmds = 4'h0;
      @(posedge clk);
      #2;
   endtask
endmodule

/* sim/motor_error_flag_manager_test.sv */
`timescale 1ns/1ps
bind motor_error_flag_manager motor_error_flag_manager_props chk (.clk(clk), .reset_n(reset_n),
   .response_cfg(response_cfg), .immediate_stop_cfg(immediate_stop_cfg),
   .motor_supply_input_low(motor_supply_input_low),
   .driver_fault(driver_fault), .cmd_stop_motor(cmd_stop_motor), .read_req(read_req),
   .read_busy(read_busy), .read_valid(read_valid), .stop_cause_flags(stop_cause_flags),
   .seen_since_clear_flags(seen_since_clear_flags), .motor_stop_req(motor_stop_req),
   .immediate_stop_req(immediate_stop_req), .error_line(error_line));
// ==========================================================
// Testbench top.
module motor_error_flag_manager_test;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic supply_low = 1'b0;
   logic drv_fault = 1'b0;
   logic [15:0] cur = 16'h0000;
   logic [15:0] limit = 16'hFFFF;
   logic [15:0] imm_cfg = 16'h0000;
   logic [31:0] resp_cfg = 32'h0000001C;
   logic [6:0] modes = 7'h01;
   logic [15:0] tmo = 16'h0000;
   logic [15:0] ev = 16'h0000;
   logic [7:0] oc_thr = 8'h01;
   logic tick = 1'b0;
   logic [11:0] in_val = 12'h000, in_min = 12'h000, in_max = 12'hFFF;
   logic [11:0] fb_val = 12'h000, fb_min = 12'h000, fb_max = 12'hFFF;
   logic read_req, read_seen, read_clear, read_busy, read_valid, hi_q = 1'b0;
   logic [3:0] cmds;
   logic [7:0] read_byte, lo_byte;
   logic [15:0] got, exp;
   logic [15:0] exp_q[$];
   int n_errors = 0;
   int checks_done = 0;
   always #25 clk = ~clk;
   host_model host (.clk(clk), .read_busy(read_busy), .read_req(read_req),
      .read_seen(read_seen), .read_clear(read_clear), .cmds(cmds));
   motor_error_flag_manager #(.TICK_CYCLES(4)) dut (.clk(clk), .reset_n(reset_n),
      .response_cfg(resp_cfg), .immediate_stop_cfg(imm_cfg), .host_input_mode(modes[0]),
      .pulse_input_mode(modes[1]), .analog_input_mode(modes[2]),
      .analog_feedback_mode(modes[3]), .input_detect_en(modes[4]),
      .feedback_detect_en(modes[5]), .crc_check_en(modes[6]),
      .timeout_ticks(tmo), .hard_oc_threshold(oc_thr), .motor_supply_input_low(supply_low),
      .driver_fault(drv_fault), .pulse_invalid(ev[3]), .input_value(in_val),
      .input_error_min(in_min), .input_error_max(in_max), .input_power_disconnect(ev[4]),
      .feedback_value(fb_val), .feedback_error_min(fb_min), .feedback_error_max(fb_max),
      .feedback_power_disconnect(ev[5]), .current_ma(cur), .soft_current_limit(limit),
      .rx_stop_bit_bad(ev[7]), .rx_hw_overrun(ev[8]), .rx_byte_dropped(ev[9]),
      .packet_crc_bad(ev[10]), .packet_malformed(ev[11]), .period_tick(tick),
      .hw_current_limiting(ev[13]), .cmd_set_target(cmds[0]), .cmd_stop_motor(cmds[1]),
      .cmd_force_duty_target(cmds[2]), .cmd_force_duty(cmds[3]), .read_req(read_req),
      .read_seen(read_seen), .read_clear(read_clear), .read_busy(read_busy),
      .read_valid(read_valid), .read_byte(read_byte), .stop_cause_flags(),
      .seen_since_clear_flags(), .motor_stop_req(), .immediate_stop_req(), .error_line());
   task automatic rd(input logic seen, input logic clear, input logic [15:0] value);
      exp_q.push_back(value);
      host.do_read(seen, clear);
   endtask
   task automatic drive_err(input int b, input logic on);
      case (b)
         5: fb_val = on ? fb_min - 12'h001 : fb_min;
         6: cur = on ? limit + 16'h0001 : 16'h0000;
         12: tmo = on ? 16'h0001 : 16'h0000;
         default: ev[b] = on;
      endcase
   endtask
   // ==========================================================
   // Control period pulse, every other cycle.
   always
   begin
      @(posedge clk);
      #2;
      tick = ~tick;
   end
   task automatic end_sim();
      if (exp_q.size() != 0)
         n_errors++;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // ==========================================================
   // Monitor: pairs the two bytes of a read and compares.
   always @(posedge clk)
   begin
      if (read_valid === 1'b1)
      begin
         if (hi_q === 1'b0)
            lo_byte = read_byte;
         else
         begin
            got = {read_byte, lo_byte};
            exp = exp_q.pop_front();
            checks_done++;
            if (got !== exp)
            begin
               n_errors++;
               $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            end
         end
         hi_q = ~hi_q;
      end
   end
   // ==========================================================
   // Stimulus.
   initial
   begin
      void'($urandom(49));
      repeat (3) @(posedge clk);
      #2;
      reset_n = 1'b1;
      imm_cfg = 16'($urandom);
      repeat (3) @(posedge clk);
      #2;
      rd(1'b0, 1'b0, 16'h0001);
      $display("test 1 done");
      drv_fault = 1'b1;
      repeat (3) @(posedge clk);
      #2;
      rd(1'b0, 1'b0, 16'h0005);
      drv_fault = 1'b0;
      repeat (3) @(posedge clk);
      #2;
      rd(1'b0, 1'b0, 16'h0001);
      $display("test 2 done");
      limit = 16'h0100 + 16'($urandom % 256);
      cur = limit + 16'h0001 + 16'($urandom % 100);
      repeat (3) @(posedge clk);
      #2;
      rd(1'b0, 1'b0, 16'h0001);
      cur = 16'h0000;
      repeat (2) @(posedge clk);
      #2;
      rd(1'b1, 1'b1, 16'h0045);
      rd(1'b1, 1'b0, 16'h0001);
      $display("test 3 done");
      host.send_cmd(4'h1);
      rd(1'b0, 1'b0, 16'h0000);
      supply_low = 1'b1;
      @(posedge clk);
      #2;
      supply_low = 1'b0;
      repeat (3) @(posedge clk);
      #2;
      rd(1'b0, 1'b0, 16'h0003);
      rd(1'b0, 1'b1, 16'h0003);
      rd(1'b0, 1'b0, 16'h0001);
      $display("test 4 done");
      for (int k = 0; k < 3; k++)
      begin
         host.send_cmd(4'h2);
         rd(1'b0, 1'b0, 16'h0001);
         host.send_cmd((k == 0) ? 4'h1 : ((k == 1) ? 4'h4 : 4'h8));
         rd(1'b0, 1'b0, 16'h0000);
      end
      $display("test 5 done");
      resp_cfg = 32'h5555555C;
      ev = 16'h0438;
      in_min = 12'h001 + 12'($urandom % 255);
      in_max = 12'h800 + 12'($urandom % 2047);
      in_val = in_min;
      fb_min = 12'h001 + 12'($urandom % 255);
      fb_max = 12'h800 + 12'($urandom % 2047);
      fb_val = fb_min;
      repeat (3) @(posedge clk);
      #2;
      rd(1'b0, 1'b0, 16'h0000);
      ev = 16'h0000;
      modes = 7'h7F;
      for (int b = 3; b < 14; b++)
      begin
         drive_err(b, 1'b1);
         repeat (6) @(posedge clk);
         #2;
         rd(1'b0, 1'b0, 16'h0001 << b);
         drive_err(b, 1'b0);
         @(posedge clk);
         #2;
      end
      in_val = in_max + 12'h001;
      repeat (3) @(posedge clk);
      #2;
      rd(1'b0, 1'b0, 16'h0010);
      in_val = in_min;
      $display("test 6 done");
      repeat (4) @(posedge clk);
      end_sim();
   end
   initial
   begin
      #200000;
      n_errors++;
      end_sim();
   end
endmodule
